// ===== rtl/frx_exec.sv
// execution datapath for complement, decrement, increment, the two skip forms and the absolute branch
// assumes the decoder presents one instruction per request pulse and waits for done before the next
`timescale 1ns/100ps
`include "frx_map.svh"
module frx_exec (
   input wire logic clk, // core clock, 25 MHz
   input wire logic nrst, // asynchronous reset, active low
   input wire logic req, // one-cycle pulse: start an instruction
   input wire frx_pkg::frx_op_t op, // instruction code
   input wire frx_pkg::frx_addr_t file_addr, // file register address
   input wire logic dest_sel, // 0 accumulator, 1 file register
   input wire frx_pkg::frx_imm_t branch_imm, // branch immediate
   input wire frx_pkg::frx_data_t program_page_latch, // page latch contents
   input wire frx_pkg::frx_pc_t pc_in, // counter of the running instruction
   input wire logic ext_wr_en, // preload a file register
   input wire frx_pkg::frx_addr_t ext_wr_addr, // preload address
   input wire frx_pkg::frx_data_t ext_wr_data, // preload data
   output frx_pkg::frx_data_t acc_out, // working accumulator
   output logic zero_flag, // zero status flag
   output frx_pkg::frx_pc_t pc_out, // program counter
   output logic busy, // instruction in progress
   output logic done, // one-cycle pulse: instruction cycle ended
   output logic skip_nop, // one-cycle pulse: next instruction replaced by no-op
   output frx_pkg::frx_data_t result_out // last result
);
   import frx_pkg::*;

   logic rst_meta_r;
   logic rst_sync_r;
   frx_state_t state_r;
   frx_op_t op_r;
   frx_addr_t addr_r;
   logic dest_r;
   frx_imm_t imm_r;
   logic [`FRX_PAGE_HI-`FRX_PAGE_LO:0] page_r;
   frx_data_t rd_data;
   frx_data_t res_nxt;
   logic mem_wr;
   frx_addr_t mem_waddr;
   frx_data_t mem_wdata;
   logic is_skip;
   logic is_flagop;
   logic res_zero;
   logic in_idle;
   logic in_exec;
   logic in_flush;
   logic is_branch;
   logic skip_taken;
   logic take_req;
   logic exec_writes;

   // reset released through two stages so all logic leaves reset on the same edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   always_comb begin
      unique case (op_r)
         `FRX_OP_COMPLEMENT_FILE_OP: res_nxt = ~rd_data;
         `FRX_OP_DECREMENT_FILE_OP, `FRX_OP_DECSZ: res_nxt = rd_data - `FRX_ONE;
         `FRX_OP_INCREMENT_FILE_OP, `FRX_OP_INCSZ: res_nxt = rd_data + `FRX_ONE;
         default: res_nxt = rd_data;
      endcase
   end

   assign res_zero = (res_nxt == `FRX_ZERO);
   assign is_skip = (op_r == `FRX_OP_DECSZ) || (op_r == `FRX_OP_INCSZ);
   assign is_flagop = (op_r == `FRX_OP_COMPLEMENT_FILE_OP) || (op_r == `FRX_OP_DECREMENT_FILE_OP) || (op_r == `FRX_OP_INCREMENT_FILE_OP);

   // state decodes shared by the datapath, the operand capture and the status pulses
   assign in_idle = (state_r == FRX_IDLE);
   assign in_exec = (state_r == FRX_EXEC);
   assign in_flush = (state_r == FRX_FLUSH);
   assign is_branch = (op_r == `FRX_OP_BRA);
   // a skip form costs the extra cycle only when its result is zero
   assign skip_taken = is_skip && res_zero;
   assign take_req = in_idle && req;
   assign exec_writes = in_exec && (is_flagop || is_skip);

   // preload port is blocked while an instruction writes so the result is never lost
   always_comb begin
      if (exec_writes && dest_r == `FRX_DEST_F) begin
         mem_wr = 1'b1;
         mem_waddr = addr_r;
         mem_wdata = res_nxt;
      end else begin
         mem_wr = ext_wr_en && in_idle;
         mem_waddr = ext_wr_addr;
         mem_wdata = ext_wr_data;
      end
   end

   frx_file_mem #(
      .DATA_W(`FRX_DATA_W),
      .ADDR_W(`FRX_ADDR_W),
      .DEPTH(`FRX_DEPTH)
   ) u_mem (
      .clk(clk),
      .wr_en(mem_wr),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(file_addr),
      .rd_data(rd_data)
   );

   // operands captured at request; the memory reads in the same edge
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         op_r <= `FRX_OP_NONE;
         addr_r <= '0;
         dest_r <= `FRX_DEST_W;
         imm_r <= '0;
         page_r <= '0;
      end else if (take_req) begin
         op_r <= op;
         addr_r <= file_addr;
         dest_r <= dest_sel;
         imm_r <= branch_imm;
         page_r <= program_page_latch[`FRX_PAGE_HI:`FRX_PAGE_LO];
      end
   end

   // sequencer: one exec cycle, plus a flush cycle for a branch or a taken skip
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r <= FRX_IDLE;
      end else begin
         unique case (state_r)
            FRX_IDLE: if (req) state_r <= FRX_EXEC;
            FRX_EXEC: begin
               if (op_r == `FRX_OP_BRA) begin
                  state_r <= FRX_FLUSH;
               end else if (is_skip && res_zero) begin
                  state_r <= FRX_FLUSH;
               end else begin
                  state_r <= FRX_IDLE;
               end
            end
            FRX_FLUSH: state_r <= FRX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         acc_out <= `FRX_ZERO;
      end else if (exec_writes && dest_r == `FRX_DEST_W) begin
         acc_out <= res_nxt;
      end
   end

   // result_out shows every arithmetic result, whichever destination took it
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         result_out <= `FRX_ZERO;
      end else if (exec_writes) begin
         result_out <= res_nxt;
      end
   end

   // skip forms and the branch leave the flag alone
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         zero_flag <= 1'b0;
      end else if (state_r == FRX_EXEC && is_flagop) begin
         zero_flag <= res_zero;
      end
   end

   // counter: branch target, or one ahead per ended instruction, two past a skipped one
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         pc_out <= `FRX_PC_RESET;
      end else if (state_r == FRX_EXEC) begin
         if (op_r == `FRX_OP_BRA) begin
            pc_out <= {page_r, imm_r};
         end else begin
            pc_out <= pc_in + `FRX_PC_W'(1);
         end
      end else if (state_r == FRX_FLUSH && op_r != `FRX_OP_BRA) begin
         pc_out <= pc_out + `FRX_PC_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         busy <= 1'b0;
      end else if (in_idle) begin
         busy <= req;
      end else if (in_exec) begin
         busy <= is_branch || skip_taken;
      end else begin
         busy <= 1'b0;
      end
   end

   // done stands in the cycle after the last cycle of every instruction, one or two cycles long
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         done <= 1'b0;
      end else begin
         done <= (in_exec && !is_branch && !skip_taken) || in_flush;
      end
   end

   // stands in the cycle of the no-op that replaces the skipped instruction
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         skip_nop <= 1'b0;
      end else begin
         skip_nop <= in_exec && skip_taken;
      end
   end
endmodule

// ===== rtl/frx_file_mem.sv
// file register memory, one write port and one registered read port
// assumes a single clock; read data appear one cycle after the address
`timescale 1ns/100ps
`include "frx_map.svh"
module frx_file_mem #(
   parameter int DATA_W = `FRX_DATA_W,
   parameter int ADDR_W = `FRX_ADDR_W,
   parameter int DEPTH = `FRX_DEPTH
) (
   input wire logic clk, // core clock
   input wire logic wr_en, // write strobe
   input wire logic [ADDR_W-1:0] wr_addr, // write address
   input wire logic [DATA_W-1:0] wr_data, // write data
   input wire logic [ADDR_W-1:0] rd_addr, // read address
   output logic [DATA_W-1:0] rd_data // registered read data
);
   logic [DATA_W-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end
endmodule

// ===== rtl/frx_map.svh
// constants for the file-register execution datapath
// included by the package and the design modules; definitions only
`ifndef FRX_MAP_SVH
`define FRX_MAP_SVH
`define FRX_DATA_W 8
`define FRX_ADDR_W 7
`define FRX_ADDR_MAX 7'h7F
`define FRX_IMM_W 11
`define FRX_PC_W 13
`define FRX_PAGE_LO 3
`define FRX_PAGE_HI 4
`define FRX_DEPTH 128
`define FRX_ONE 8'h01
`define FRX_ZERO 8'h00
`define FRX_PC_RESET 13'h0000
`define FRX_OP_W 3
`define FRX_OP_NONE 3'h0
`define FRX_OP_COMPLEMENT_FILE_OP 3'h1
`define FRX_OP_DECREMENT_FILE_OP 3'h2
`define FRX_OP_INCREMENT_FILE_OP 3'h3
`define FRX_OP_DECSZ 3'h4
`define FRX_OP_INCSZ 3'h5
`define FRX_OP_BRA 3'h6
`define FRX_DEST_W 1'b0
`define FRX_DEST_F 1'b1
`endif

// ===== rtl/frx_pkg.sv
// types for the file-register execution datapath
// assumes frx_map.svh is on the include path
`include "frx_map.svh"
package frx_pkg;
   typedef logic [`FRX_OP_W-1:0] frx_op_t;
   typedef logic [`FRX_DATA_W-1:0] frx_data_t;
   typedef logic [`FRX_ADDR_W-1:0] frx_addr_t;
   typedef logic [`FRX_PC_W-1:0] frx_pc_t;
   typedef logic [`FRX_IMM_W-1:0] frx_imm_t;
   typedef enum logic [2:0] {
      FRX_IDLE = 3'b001,
      FRX_EXEC = 3'b010,
      FRX_FLUSH = 3'b100
   } frx_state_t;
endpackage

// ===== test/frx_exec_asserts.sv
// checker for frx_exec: pulse widths, skip sequence and answer timing at the ports
// assumes it is bound onto frx_exec and that everything runs on clk
`timescale 1ns/100ps
module frx_exec_asserts (
   input wire logic clk, // core clock
   input wire logic nrst, // reset, active low
   input wire logic req, // start pulse
   input wire logic done, // end pulse
   input wire logic busy, // in progress
   input wire logic skip_nop, // skip pulse
   input wire logic zero_flag, // zero flag
   input wire frx_pkg::frx_pc_t pc_out, // program counter
   input wire frx_pkg::frx_data_t result_out // last result
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_done_one_cycle: assert property (done |=> !done) else $error("done held");
   a_skip_one_cycle: assert property (skip_nop |=> !skip_nop) else $error("skip held");
   a_skip_then_done: assert property (skip_nop |=> done && !busy) else $error("skip end late");
   a_skip_busy: assert property (skip_nop |-> busy && !done) else $error("skip not busy");
   a_skip_on_zero: assert property (skip_nop |-> result_out == 8'h00) else $error("skip on nonzero");
   a_skip_flag_hold: assert property (skip_nop |-> $stable(zero_flag)) else $error("skip moved flag");
   a_skip_pc_step: assert property (skip_nop |=> pc_out == $past(pc_out) + 13'h0001) else $error("skip pc");
   a_req_answer: assert property (req && !busy && !done |-> ##[1:4] done) else $error("no done");
   a_done_idle: assert property (done |-> !busy) else $error("done while busy");
endmodule
bind frx_exec frx_exec_asserts frx_exec_asserts_inst (.clk(clk), .nrst(nrst), .req(req), .done(done),
   .busy(busy), .skip_nop(skip_nop), .zero_flag(zero_flag), .pc_out(pc_out), .result_out(result_out));

// ===== test/tb.sv
// self-checking bench for frx_exec: corner cases, then random instructions
// assumes the design files and frx_map.svh are compiled first
`timescale 1ns/100ps
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin n_mismatch++; $display("unexpected at %0t: %h vs %h", $time, g, w); end end
module tb;
   import frx_pkg::*;
   logic clk = 0, nrst = 0, req = 0, dest_sel = 0, ext_wr_en = 0, z_m = 0, done, busy, skip_nop, zero_flag;
   frx_op_t op = '0;
   frx_addr_t file_addr = '0, ext_wr_addr = '0;
   frx_imm_t branch_imm = '0;
   frx_data_t program_page_latch = '0, ext_wr_data = '0, acc_m = '0, res_m = '0, acc_out, result_out;
   frx_data_t mem [128];
   frx_pc_t pc_in = '0, pc_out;
   int seed = 32'h175e, n_mismatch = 0, checks_done = 0;
   always #20 clk = ~clk;
   frx_exec frx_exec_inst (.clk(clk), .nrst(nrst), .req(req), .op(op), .file_addr(file_addr), .dest_sel(dest_sel),
      .branch_imm(branch_imm), .program_page_latch(program_page_latch), .pc_in(pc_in), .ext_wr_en(ext_wr_en),
      .ext_wr_addr(ext_wr_addr), .ext_wr_data(ext_wr_data), .acc_out(acc_out), .zero_flag(zero_flag),
      .pc_out(pc_out), .busy(busy), .done(done), .skip_nop(skip_nop), .result_out(result_out));
   function automatic frx_data_t calc(frx_op_t o, frx_data_t v);
      case (o)
         3'h1: return ~v;
         3'h2, 3'h4: return v - 8'h01;
         default: return v + 8'h01;
      endcase
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic pre(frx_addr_t a, frx_data_t v);
      @(posedge clk);
      ext_wr_en <= 1'b1;
      ext_wr_addr <= a;
      ext_wr_data <= v;
      mem[a] = v;
      @(posedge clk);
      ext_wr_en <= 1'b0;
   endtask
   task automatic run(frx_op_t o, frx_addr_t a, logic d);
      frx_data_t r, pg;
      frx_imm_t k;
      frx_pc_t pci, ep;
      int n;
      logic sk, seen;
      r = calc(o, mem[a]);
      k = 11'($random(seed));
      pg = 8'($random(seed));
      pci = 13'($random(seed));
      sk = 0;
      seen = 0;
      n = 0;
      @(posedge clk);
      req <= 1'b1;
      op <= o;
      file_addr <= a;
      dest_sel <= d;
      branch_imm <= k;
      program_page_latch <= pg;
      pc_in <= pci;
      @(posedge clk);
      req <= 1'b0;
      #1;
      while (done !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
         seen |= skip_nop;
      end
      if (o inside {[3'h1:3'h5]}) begin
         res_m = r;
         if (d) mem[a] = r;
         else acc_m = r;
         if (o < 3'h4) z_m = (r == 8'h00);
         sk = o > 3'h3 && r == 8'h00;
      end
      // a taken skip steps the counter past the replaced instruction
      ep = (o == 3'h6) ? {pg[4:3], k} : pci + 13'h0001 + {12'h000, sk};
      `CHK(n, (o == 3'h6 || sk) ? 2 : 1)
      `CHK(seen, sk)
      `CHK(acc_out, acc_m)
      `CHK(result_out, res_m)
      `CHK(zero_flag, z_m)
      if (o inside {[3'h1:3'h6]}) `CHK(pc_out, ep)
      $display("test op %0d at %h ended", o, a);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 128; i++) pre(7'(i), 8'($random(seed)));
      pre(7'h7F, 8'hFF);
      run(3'h5, 7'h7F, 1'b1);
      run(3'h4, 7'h7F, 1'b0);
      pre(7'h05, 8'hFF);
      run(3'h1, 7'h05, 1'b0);
      pre(7'h06, 8'h01);
      run(3'h2, 7'h06, 1'b1);
      run(3'h3, 7'h06, 1'b1);
      run(3'h4, 7'h06, 1'b0);
      for (int i = 0; i < 8; i++) run(3'(i), 7'h00, 1'b0);
      repeat (200) run(3'($random(seed)), 7'($random(seed)), 1'($random(seed)));
      summarize();
   end
   initial begin
      #400000;
      n_mismatch++;
      summarize();
   end
endmodule
